// File: logic/cfa_pkg.sv
// shared constants, state and mode encodings, helper functions for the camera front end
// assumes a single system clock at the rate below and a camera-driven pixel clock
package cfa_pkg;
  // ===========================================================
  // sizes
  localparam int PIX_W   = 16;
  localparam int LUT_AW  = 16;
  localparam int LUT_DW  = 16;
  localparam int FIFO_AW = 14;
  localparam int FIFO_DW = 32;
  localparam int PTR_W   = FIFO_AW + 1;
  localparam int EXPO_W  = 27;
  // ===========================================================
  // timing
  localparam int SYS_PERIOD_NS = 40;
  localparam int SYS_HZ        = 25_000_000;
  localparam int EXPO_US_NS    = 1000;
  localparam int EXPO_MS_NS    = 1_000_000;
  localparam int LINE_START_NS = 160;
  localparam int STROBE_HZ [18] = '{250_000, 500_000, 1_000_000, 2_000_000, 2_500_000,
    3_125_000, 4_000_000, 5_000_000, 6_250_000, 8_000_000, 10_000_000, 12_500_000,
    16_000_000, 20_000_000, 25_000_000, 33_000_000, 40_000_000, 50_000_000};
  localparam int BAUD_HZ [8] = '{600, 1200, 2400, 4800, 9600, 19200, 28800, 57600};
  // ===========================================================
  // encodings
  typedef enum logic [1:0] {
    ACQ_IDLE  = 2'h0,
    ACQ_WAIT  = 2'h1,
    ACQ_RUN   = 2'h3,
    ACQ_FLUSH = 2'h2
  } cfa_acq_t;
  localparam logic [2:0] PAR_NONE  = 3'h0;
  localparam logic [2:0] PAR_ODD   = 3'h1;
  localparam logic [2:0] PAR_EVEN  = 3'h2;
  localparam logic [2:0] PAR_MARK  = 3'h3;
  localparam logic [2:0] PAR_SPACE = 3'h4;
  localparam logic [1:0] IO_INPUT  = 2'h0;
  localparam logic [1:0] IO_HIGH   = 2'h1;
  localparam logic [1:0] IO_LOW    = 2'h2;
  // ===========================================================
  // helpers
  function automatic logic par_bit(input logic [7:0] d, input logic b8, input logic [2:0] m);
    logic x;
    x = ^(b8 ? d : {1'b0, d[6:0]});
    case (m)
      PAR_ODD:  par_bit = ~x;
      PAR_EVEN: par_bit = x;
      PAR_MARK: par_bit = 1'b1;
      default:  par_bit = 1'b0;
    endcase
  endfunction
  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    gray2bin = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      gray2bin[i] = gray2bin[i+1] ^ g[i];
    end
  endfunction
endpackage

// File: logic/cfa_ram.sv
// simple dual-port memory, separate write and read clocks, registered read data
// assumes the user keeps read and write of one address apart in time
`timescale 1ns/1ps
module cfa_ram #(
  parameter int AW = 16,
  parameter int DW = 16
) (
  input  wire logic          i_wclk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_rclk,
  input  wire logic          i_rrst,
  input  wire logic          i_re,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [2**AW];
  always_ff @(posedge i_wclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end
  // read data holds between reads so the consumer may stall
  always_ff @(posedge i_rclk) begin
    if (i_rrst) begin
      o_rdata <= '0;
    end else if (i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule

// File: logic/cfa_top.sv
// camera acquisition front end: capture, window, lookup, packing, fifo, camera control
// assumes the camera pixel clock runs continuously; config is held steady while armed
//
// Summary of operation
// RL1 - up to 16 data bits, per-bit mask
// RL2 - every pixel looked up in 64k x16 table
// RL3 - table contents may rotate msb to msb
// RL4 - masked bits never reach unreachable table entries
// RL5 - two taps looked up jointly, independent mapping
// RL6 - 16384 by 32 bit fifo buffers data
// RL7 - pack 8 or 16 bit results into words
// RL8 - sample on selected strobe edge
// RL9 - camera keeps strobe within rate limits
// RL10 - generate strobe at selected rate, edge; code rounds the half period down to whole cycles and tops out at sys/2
// RL11 - clock driven out on control line a
// RL12 - area window and offsets up to 8192
// RL13 - line window to 65535, single step
// RL14 - keep every 1st, 2nd, 4th or 8th pixel and line
// RL15 - line and frame valid polarity selectable
// RL16 - line scan drives line start pulse
// RL17 - four control lines input, high, low
// RL18 - four output lines set high or low
// RL19 - serial port formats and baud rates
// RL20 - timed exposure pulse, us or ms units
// RL21 - completion flag and enabled interrupt
// RL22 - complete only after last word written
`timescale 1ns/1ps
module cfa_top #(
  parameter int SYS_CLK_HZ     = cfa_pkg::SYS_HZ,
  parameter int EXPO_MS_CYCLES = cfa_pkg::EXPO_MS_NS / cfa_pkg::SYS_PERIOD_NS
) (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  input  wire logic        I_CLK_PIX,
  input  wire logic [15:0] I_PIX_DATA,
  input  wire logic        I_LINE_VALID,
  input  wire logic        I_FRAME_VALID,
  input  wire logic [15:0] I_PIX_MASK,
  input  wire logic        I_EDGE_FALL,
  input  wire logic        I_LV_LOW,
  input  wire logic        I_FV_LOW,
  input  wire logic        I_LINE_SCAN,
  input  wire logic        I_PIX16,
  input  wire logic [1:0]  I_SUBSAMPLE,
  input  wire logic [15:0] I_WINDOW_X,
  input  wire logic [15:0] I_WINDOW_Y,
  input  wire logic [15:0] I_WINDOW_W,
  input  wire logic [15:0] I_WINDOW_H,
  input  wire logic        I_ACQ_START,
  input  wire logic        I_ACQ_CLEAR,
  input  wire logic        I_IRQ_EN,
  output logic             O_ACQ_DONE,
  output logic             O_ACQ_IRQ,
  output logic             O_FIFO_OVERFLOW,
  input  wire logic        I_LUT_WE,
  input  wire logic [15:0] I_LUT_ADDR,
  input  wire logic [15:0] I_LUT_DATA,
  input  wire logic        I_FIFO_READ,
  output logic      [31:0] O_FIFO_DATA,
  output logic             O_FIFO_VALID,
  input  wire logic        I_STROBE_DRIVE,
  input  wire logic        I_STROBE_INVERT,
  input  wire logic [4:0]  I_STROBE_RATE,
  input  wire logic        I_CLK_ON_IO,
  output logic             O_STROBE_OUT,
  output logic             O_STROBE_OE,
  input  wire logic        I_LINE_START_EN,
  input  wire logic [15:0] I_LINE_PERIOD,
  output logic             O_LINE_START,
  input  wire logic [3:0]  I_IO_IN,
  input  wire logic [7:0]  I_IO_MODE,
  output logic      [3:0]  O_IO_OUT,
  output logic      [3:0]  O_IO_OE,
  output logic      [3:0]  O_IO_STATE,
  input  wire logic [1:0]  I_TRIGGER_INPUT,
  output logic      [1:0]  O_TRIGGER_STATE,
  input  wire logic [3:0]  I_OUT_LEVEL,
  input  wire logic        I_EXPO_EN,
  input  wire logic        I_EXPO_FIRE,
  input  wire logic        I_EXPO_MS,
  input  wire logic [26:0] I_EXPO_WIDTH,
  output logic      [3:0]  O_OUT_LINE,
  output logic             O_EXPO_BUSY,
  input  wire logic        I_SER_RX,
  input  wire logic        I_SER_BITS8,
  input  wire logic        I_SER_STOP2,
  input  wire logic [2:0]  I_SER_PARITY,
  input  wire logic [2:0]  I_SER_BAUD,
  input  wire logic        I_TX_VALID,
  input  wire logic [7:0]  I_TX_DATA,
  output logic             O_SER_TX,
  output logic             O_TX_READY,
  output logic      [7:0]  O_RX_DATA,
  output logic             O_RX_VALID,
  output logic             O_RX_ERR
);
  localparam int CFG_W    = 87;
  localparam int EXPO_US  = cfa_pkg::EXPO_US_NS / cfa_pkg::SYS_PERIOD_NS;
  localparam int LS_CYC   = cfa_pkg::LINE_START_NS / cfa_pkg::SYS_PERIOD_NS;
  localparam int PW       = cfa_pkg::PTR_W;
  // above sys/2 the generator saturates at one cycle per half period
  function automatic logic [31:0] half_cyc(input logic [4:0] s);
    int q;
    q = SYS_CLK_HZ / (2 * cfa_pkg::STROBE_HZ[(s > 5'd17) ? 17 : s]);
    half_cyc = (q < 1) ? 32'h1 : 32'(q);
  endfunction
  function automatic logic [31:0] baud_cyc(input logic [2:0] s);
    baud_cyc = 32'(SYS_CLK_HZ / cfa_pkg::BAUD_HZ[s]);
  endfunction

  // ===========================================================
  // crossings
  logic [CFG_W-1:0] cfg_sys, cfg_s1, cfg_l;
  logic             rst_s1, rst_l, start_tg, st_s1, st_s2, st_s3, start_ev;
  logic             done_tg, dn_s1, dn_s2, dn_s3, ovf_l, ov_s1;
  logic [PW-1:0]    wgray, wg_s1, wg_s2, rgray, rg_s1, rg_s2;
  always_ff @(posedge I_CLK_SYS) begin
    cfg_sys <= {I_PIX_MASK, I_EDGE_FALL, I_LV_LOW, I_FV_LOW, I_LINE_SCAN, I_PIX16,
                I_SUBSAMPLE, I_WINDOW_X, I_WINDOW_Y, I_WINDOW_W, I_WINDOW_H};
    if (I_RST) start_tg <= 1'b0;
    else if (I_ACQ_START) start_tg <= ~start_tg;
    {dn_s1, dn_s2, dn_s3} <= {done_tg, dn_s1, dn_s2};
    {ov_s1, O_FIFO_OVERFLOW} <= {ovf_l, ov_s1};
    {wg_s1, wg_s2} <= {wgray, wg_s1};
  end
  // quasi-static config: software changes it only while idle
  always_ff @(posedge I_CLK_PIX) begin
    {rst_s1, rst_l} <= {I_RST, rst_s1};
    {cfg_s1, cfg_l} <= {cfg_sys, cfg_s1};
    {st_s1, st_s2, st_s3} <= {start_tg, st_s1, st_s2};
    {rg_s1, rg_s2} <= {rgray, rg_s1};
  end
  assign start_ev = st_s2 ^ st_s3;
  logic [15:0] c_mask, c_x, c_y, c_w, c_h;
  logic        c_fall, c_lvl, c_fvl, c_ls, c_p16;
  logic [1:0]  c_sub;
  assign {c_mask, c_fall, c_lvl, c_fvl, c_ls, c_p16, c_sub, c_x, c_y, c_w, c_h} = cfg_l;

  // ===========================================================
  // pixel capture and window
  logic [15:0] cp_d, cn_d, px_d, pix_cnt, line_cnt, px_off, ln_off, sub_m;
  logic        cp_lv, cp_fv, cn_lv, cn_fv, lv, fv, lv_q, fv_q, in_win, frame_end;
  cfa_pkg::cfa_acq_t st;
  always_ff @(posedge I_CLK_PIX) {cp_d, cp_lv, cp_fv} <= {I_PIX_DATA, I_LINE_VALID, I_FRAME_VALID};
  always_ff @(negedge I_CLK_PIX) {cn_d, cn_lv, cn_fv} <= {I_PIX_DATA, I_LINE_VALID, I_FRAME_VALID};
  always_ff @(posedge I_CLK_PIX) begin
    px_d <= c_fall ? cn_d : cp_d; // RL8
    lv   <= (c_fall ? cn_lv : cp_lv) ^ c_lvl; // RL15
    fv   <= (c_fall ? cn_fv : cp_fv) ^ c_fvl; // RL15
    lv_q <= lv;
    fv_q <= fv;
  end
  always_ff @(posedge I_CLK_PIX) begin
    if (rst_l || !lv) pix_cnt <= '0;
    else pix_cnt <= pix_cnt + 16'h1;
    if (rst_l || start_ev || (!c_ls && fv && !fv_q)) line_cnt <= '0;
    else if (!lv && lv_q) line_cnt <= line_cnt + 16'h1;
  end
  assign px_off = pix_cnt - c_x;
  assign ln_off = line_cnt - c_y;
  assign sub_m  = ~(16'hffff << c_sub);
  assign in_win = (st == cfa_pkg::ACQ_RUN) && lv && (c_ls || fv)
                  && (pix_cnt >= c_x) && (px_off < c_w) // RL12 RL13
                  && (line_cnt >= c_y) && (ln_off < c_h) // RL12 RL13
                  && ((px_off & sub_m) == 16'h0) && ((ln_off & sub_m) == 16'h0); // RL14
  assign frame_end = (st == cfa_pkg::ACQ_RUN) && (c_ls
                     ? (!lv && lv_q && (line_cnt == 16'(c_y + c_h - 16'h1)))
                     : (!fv && fv_q));

  // ===========================================================
  // acquisition state
  logic [2:0] end_p;
  logic       ovf_set;
  always_ff @(posedge I_CLK_PIX) begin
    if (rst_l) begin
      st <= cfa_pkg::ACQ_IDLE;
      done_tg <= 1'b0;
      end_p <= '0;
      ovf_l <= 1'b0;
    end else begin
      end_p <= {end_p[1:0], frame_end};
      if (start_ev) ovf_l <= 1'b0;
      else if (ovf_set) ovf_l <= 1'b1;
      if (start_ev) begin
        st <= c_ls ? cfa_pkg::ACQ_RUN : cfa_pkg::ACQ_WAIT;
      end else begin
        case (st)
          cfa_pkg::ACQ_WAIT: if (fv && !fv_q) st <= cfa_pkg::ACQ_RUN;
          cfa_pkg::ACQ_RUN: if (frame_end) st <= cfa_pkg::ACQ_FLUSH;
          cfa_pkg::ACQ_FLUSH: if (end_p[2]) begin
            st <= cfa_pkg::ACQ_IDLE;
            done_tg <= ~done_tg; // RL22
          end
          default: st <= cfa_pkg::ACQ_IDLE;
        endcase
      end
    end
  end

  // ===========================================================
  // lookup and packing
  logic [15:0] lut_addr, lut_q;
  logic [31:0] pk_word, merged, wr_data;
  logic [1:0]  pk_cnt;
  logic        lut_rd, lut_v, wr, pk_last, full;
  logic [PW-1:0] wptr, rbin_l;
  always_ff @(posedge I_CLK_PIX) begin
    lut_rd   <= in_win && !rst_l;
    lut_addr <= px_d & c_mask; // RL1 RL4 RL5
    lut_v    <= lut_rd && !rst_l;
  end
  // table applies any mapping, including msb-aligning rotation
  cfa_ram #(.AW(cfa_pkg::LUT_AW), .DW(cfa_pkg::LUT_DW)) u_lut ( // RL2 RL3
    .i_wclk  (I_CLK_SYS),
    .i_we    (I_LUT_WE),
    .i_waddr (I_LUT_ADDR),
    .i_wdata (I_LUT_DATA),
    .i_rclk  (I_CLK_PIX),
    .i_rrst  (rst_l),
    .i_re    (lut_rd),
    .i_raddr (lut_addr),
    .o_rdata (lut_q)
  );
  assign pk_last = c_p16 ? pk_cnt[0] : (pk_cnt == 2'h3);
  always_comb begin
    merged = pk_word;
    if (c_p16) merged[{pk_cnt[0], 4'h0} +: 16] = lut_q;
    else merged[{pk_cnt, 3'h0} +: 8] = lut_q[7:0];
  end
  always_ff @(posedge I_CLK_PIX) begin
    if (rst_l || start_ev) begin
      pk_cnt <= '0;
      pk_word <= '0;
      wr <= 1'b0;
      wr_data <= '0;
    end else begin
      wr <= 1'b0;
      if (lut_v) begin
        if (pk_last) begin // RL7
          wr <= 1'b1;
          wr_data <= merged;
          pk_word <= '0;
          pk_cnt <= '0;
        end else begin
          pk_word <= merged;
          pk_cnt <= pk_cnt + 2'h1;
        end
      end else if (end_p[1] && pk_cnt != 2'h0) begin // RL22
        wr <= 1'b1;
        wr_data <= pk_word;
        pk_word <= '0;
        pk_cnt <= '0;
      end
    end
  end

  // ===========================================================
  // fifo pointers
  logic [PW-1:0] rptr, wbin_s;
  logic          rd_en, empty;
  assign rbin_l  = cfa_pkg::gray2bin(rg_s2);
  assign full    = (wptr[PW-1] != rbin_l[PW-1]) && (wptr[PW-2:0] == rbin_l[PW-2:0]);
  assign ovf_set = wr && full;
  always_ff @(posedge I_CLK_PIX) begin
    if (rst_l) begin
      wptr <= '0;
      wgray <= '0;
    end else if (wr && !full) begin
      wptr <= wptr + 1'b1;
      wgray <= (wptr + 1'b1) ^ ((wptr + 1'b1) >> 1);
    end
  end
  assign wbin_s = cfa_pkg::gray2bin(wg_s2);
  assign empty  = (rptr == wbin_s);
  assign rd_en  = !empty && (!O_FIFO_VALID || I_FIFO_READ);
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      rptr <= '0;
      rgray <= '0;
      O_FIFO_VALID <= 1'b0;
    end else begin
      if (rd_en) begin
        rptr <= rptr + 1'b1;
        rgray <= (rptr + 1'b1) ^ ((rptr + 1'b1) >> 1);
      end
      if (rd_en) O_FIFO_VALID <= 1'b1;
      else if (I_FIFO_READ) O_FIFO_VALID <= 1'b0;
    end
  end
  cfa_ram #(.AW(cfa_pkg::FIFO_AW), .DW(cfa_pkg::FIFO_DW)) u_fifo ( // RL6
    .i_wclk  (I_CLK_PIX),
    .i_we    (wr && !full),
    .i_waddr (wptr[PW-2:0]),
    .i_wdata (wr_data),
    .i_rclk  (I_CLK_SYS),
    .i_rrst  (I_RST),
    .i_re    (rd_en),
    .i_raddr (rptr[PW-2:0]),
    .o_rdata (O_FIFO_DATA)
  );

  // ===========================================================
  // completion
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) O_ACQ_DONE <= 1'b0;
    else if (dn_s2 ^ dn_s3) O_ACQ_DONE <= 1'b1; // RL21
    else if (I_ACQ_CLEAR) O_ACQ_DONE <= 1'b0;
    O_ACQ_IRQ <= !I_RST && O_ACQ_DONE && I_IRQ_EN; // RL21
  end

  // ===========================================================
  // strobe generator, line start, control lines
  logic [31:0] sg_cnt;
  logic [15:0] ls_cnt;
  logic        sg;
  logic [3:0]  io_s1;
  logic [1:0]  tr_s1;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || !(I_STROBE_DRIVE || I_CLK_ON_IO)) begin
      sg_cnt <= '0;
      sg <= 1'b0;
    end else if (sg_cnt >= half_cyc(I_STROBE_RATE) - 32'h1) begin // RL10
      sg_cnt <= '0;
      sg <= ~sg;
    end else sg_cnt <= sg_cnt + 32'h1;
    O_STROBE_OUT <= !I_RST && (sg ^ I_STROBE_INVERT); // RL10
    O_STROBE_OE <= !I_RST && I_STROBE_DRIVE;
    if (I_RST || !(I_LINE_SCAN && I_LINE_START_EN) || ls_cnt >= I_LINE_PERIOD) ls_cnt <= '0;
    else ls_cnt <= ls_cnt + 16'h1;
    O_LINE_START <= !I_RST && I_LINE_SCAN && I_LINE_START_EN && (ls_cnt < 16'(LS_CYC)); // RL16
    {io_s1, O_IO_STATE} <= {I_IO_IN, io_s1}; // RL17
    {tr_s1, O_TRIGGER_STATE} <= {I_TRIGGER_INPUT, tr_s1}; // RL17
  end
  for (genvar gi = 0; gi < 4; gi++) begin : g_io
    always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
        O_IO_OUT[gi] <= 1'b0;
        O_IO_OE[gi] <= 1'b0;
      end else if (gi == 0 && I_CLK_ON_IO) begin
        O_IO_OUT[gi] <= sg ^ I_STROBE_INVERT; // RL11
        O_IO_OE[gi] <= 1'b1;
      end else begin
        O_IO_OUT[gi] <= (I_IO_MODE[2*gi +: 2] == cfa_pkg::IO_HIGH); // RL17
        O_IO_OE[gi] <= (I_IO_MODE[2*gi +: 2] == cfa_pkg::IO_HIGH)
                       || (I_IO_MODE[2*gi +: 2] == cfa_pkg::IO_LOW);
      end
    end
  end

  // ===========================================================
  // exposure pulse on output line a
  logic [31:0] ex_pre;
  logic [26:0] ex_left;
  logic        ex_ms;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      ex_left <= '0;
      ex_pre <= '0;
      ex_ms <= 1'b0;
    end else if (I_EXPO_FIRE && I_EXPO_WIDTH != 27'h0) begin
      ex_left <= I_EXPO_WIDTH;
      ex_pre <= '0;
      ex_ms <= I_EXPO_MS;
    end else if (ex_left != 27'h0) begin
      if (ex_pre >= 32'(ex_ms ? EXPO_MS_CYCLES : EXPO_US) - 32'h1) begin // RL20
        ex_pre <= '0;
        ex_left <= ex_left - 27'h1;
      end else ex_pre <= ex_pre + 32'h1;
    end
    O_EXPO_BUSY <= !I_RST && ex_left != 27'h0;
    if (I_RST) O_OUT_LINE <= '0;
    else O_OUT_LINE <= {I_OUT_LEVEL[3:1], I_EXPO_EN ? (ex_left != 27'h0) : I_OUT_LEVEL[0]}; // RL18
  end

  // ===========================================================
  // serial port
  logic [11:0] tx_fr, tx_sh;
  logic [3:0]  tx_n, fr_n, rx_n, rx_k;
  logic [31:0] tx_bc, rx_bc;
  logic [10:0] rx_sh, rx_w;
  logic        rx_s1, rx_s2, rx_q, par_on;
  assign par_on = (I_SER_PARITY != cfa_pkg::PAR_NONE);
  // start, seven data bits and one stop make the shortest frame of nine bits
  assign fr_n = 4'd9 + {3'h0, I_SER_BITS8} + {3'h0, par_on} + {3'h0, I_SER_STOP2};
  always_comb begin
    tx_fr = 12'hfff;
    tx_fr[0] = 1'b0;
    if (I_SER_BITS8) tx_fr[8:1] = I_TX_DATA;
    else tx_fr[7:1] = I_TX_DATA[6:0];
    if (par_on) tx_fr[I_SER_BITS8 ? 9 : 8] = cfa_pkg::par_bit(I_TX_DATA, I_SER_BITS8,
                                                               I_SER_PARITY); // RL19
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      tx_sh <= 12'hfff;
      tx_n <= '0;
      tx_bc <= '0;
      O_TX_READY <= 1'b1;
    end else if (I_TX_VALID && O_TX_READY) begin
      tx_sh <= tx_fr;
      tx_n <= fr_n;
      tx_bc <= '0;
      O_TX_READY <= 1'b0;
    end else if (tx_n != 4'h0) begin
      if (tx_bc >= baud_cyc(I_SER_BAUD) - 32'h1) begin // RL19
        tx_bc <= '0;
        tx_sh <= {1'b1, tx_sh[11:1]};
        tx_n <= tx_n - 4'h1;
        if (tx_n == 4'h1) O_TX_READY <= 1'b1;
      end else tx_bc <= tx_bc + 32'h1;
    end
    O_SER_TX <= I_RST || tx_sh[0];
  end
  assign rx_w = 11'({rx_s2, rx_sh[10:1]} >> (4'd11 - rx_k));
  always_ff @(posedge I_CLK_SYS) begin
    {rx_s1, rx_s2, rx_q} <= {I_SER_RX, rx_s1, rx_s2};
    O_RX_VALID <= 1'b0;
    if (I_RST) begin
      rx_n <= '0;
      rx_k <= '0;
      rx_bc <= '0;
      rx_sh <= '0;
      O_RX_DATA <= '0;
      O_RX_ERR <= 1'b0;
    end else if (rx_n == 4'h0) begin
      if (rx_q && !rx_s2) begin
        rx_n <= fr_n - {3'h0, I_SER_STOP2};
        rx_k <= fr_n - {3'h0, I_SER_STOP2};
        rx_bc <= baud_cyc(I_SER_BAUD) >> 1;
      end
    end else if (rx_bc == 32'h0) begin
      rx_bc <= baud_cyc(I_SER_BAUD) - 32'h1;
      rx_sh <= {rx_s2, rx_sh[10:1]};
      rx_n <= rx_n - 4'h1;
      if (rx_n == 4'h1) begin
        O_RX_VALID <= 1'b1;
        O_RX_DATA <= I_SER_BITS8 ? rx_w[8:1] : {1'b0, rx_w[7:1]};
        O_RX_ERR <= rx_w[0] || !rx_w[rx_k - 4'h1] || (par_on && (rx_w[rx_k - 4'h2]
                    != cfa_pkg::par_bit(rx_w[8:1], I_SER_BITS8, I_SER_PARITY))); // RL19
      end
    end else rx_bc <= rx_bc - 32'h1;
  end

  // ===========================================================
  // checks
  property p_done_after_flush;
    @(posedge I_CLK_PIX) disable iff (rst_l)
      $changed(done_tg) |-> $past(st) == cfa_pkg::ACQ_FLUSH && $past(end_p[2]);
  endproperty
  a_done_after_flush: assert property (p_done_after_flush) // RL22
    else $error("completion without flush");
  property p_mask_addr;
    @(posedge I_CLK_PIX) disable iff (rst_l) lut_rd |-> (lut_addr & ~c_mask) == 16'h0;
  endproperty
  a_mask_addr: assert property (p_mask_addr) // RL4
    else $error("lookup address outside mask");
  property p_subsample;
    @(posedge I_CLK_PIX) disable iff (rst_l)
      lut_rd |-> (($past(pix_cnt) - c_x) & sub_m) == 16'h0 && $past(lv);
  endproperty
  a_subsample: assert property (p_subsample) // RL14
    else $error("pixel taken off the sub-sample grid");
  property p_pack;
    @(posedge I_CLK_PIX) disable iff (rst_l) wr |-> $past(lut_v) || $past(end_p[1]);
  endproperty
  a_pack: assert property (p_pack) // RL7
    else $error("word written without packing event");
  property p_fill;
    @(posedge I_CLK_PIX) disable iff (rst_l) (PW'(wptr - rbin_l)) <= PW'(2**cfa_pkg::FIFO_AW);
  endproperty
  a_fill: assert property (p_fill) // RL6
    else $error("fifo fill beyond depth");
  property p_irq;
    @(posedge I_CLK_SYS) disable iff (I_RST) O_ACQ_DONE && I_IRQ_EN |=> O_ACQ_IRQ;
  endproperty
  a_irq: assert property (p_irq) // RL21
    else $error("interrupt missing on completion");
  property p_out_line;
    @(posedge I_CLK_SYS) disable iff (I_RST) !I_EXPO_EN |=> O_OUT_LINE == $past(I_OUT_LEVEL);
  endproperty
  a_out_line: assert property (p_out_line) // RL18
    else $error("output lines not following level");
  property p_io_high;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      I_IO_MODE[7:6] == cfa_pkg::IO_HIGH |=> O_IO_OE[3] && O_IO_OUT[3];
  endproperty
  a_io_high: assert property (p_io_high) // RL17
    else $error("control line not driven high");
endmodule

// File: test/cfa_cam.sv
// camera model: area scan frames of W pixels by H lines
// assumes a free running pixel clock, sampled on its rising edge
`timescale 1ns/1ps
module cfa_cam #(parameter int W = 6, parameter int H = 3) (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  output logic      [15:0] o_data = 16'h5a5a,
  output logic             o_lv = 1'b0,
  output logic             o_fv = 1'b0
);
  // ==========
  // frame generator, launched on the falling edge for clean sampling
  always @(posedge i_go) begin
    @(negedge i_clk) o_fv <= 1'b1;
    for (int y = 0; y < H; y++) begin
      repeat (2) @(negedge i_clk);
      o_lv <= 1'b1;
      for (int x = 0; x < W; x++) begin
        o_data <= 16'hc300 | 16'(y * 16 + x);
        @(negedge i_clk);
      end
      o_lv <= 1'b0;
      // released bus shows inverse, not a stale pixel
      o_data <= ~o_data;
    end
    repeat (2) @(negedge i_clk);
    o_fv <= 1'b0;
  end
endmodule

// File: test/test_cfa_top.sv
// bench for the camera front end: table load, windowed frame, control lines
// assumes cfa_cam as camera; serial line looped back to itself
`timescale 1ns/1ps
module test_cfa_top;
  logic I_CLK_SYS = 0, I_CLK_PIX = 0, I_RST = 1, I_LINE_VALID, I_FRAME_VALID, go = 0;
  logic I_EDGE_FALL, I_LV_LOW, I_FV_LOW, I_LINE_SCAN, I_PIX16, I_ACQ_START, I_ACQ_CLEAR;
  logic I_IRQ_EN, I_LUT_WE, I_FIFO_READ, I_STROBE_DRIVE, I_STROBE_INVERT, I_CLK_ON_IO;
  logic I_LINE_START_EN, I_EXPO_EN, I_EXPO_FIRE, I_EXPO_MS, I_SER_RX, I_SER_BITS8;
  logic I_SER_STOP2, I_TX_VALID, O_ACQ_DONE, O_ACQ_IRQ, O_FIFO_OVERFLOW, O_FIFO_VALID;
  logic O_STROBE_OUT, O_STROBE_OE, O_LINE_START, O_EXPO_BUSY, O_SER_TX, O_TX_READY;
  logic O_RX_VALID, O_RX_ERR;
  logic [1:0] I_SUBSAMPLE, I_TRIGGER_INPUT, O_TRIGGER_STATE;
  logic [2:0] I_SER_PARITY, I_SER_BAUD;
  logic [3:0] I_IO_IN, I_OUT_LEVEL, O_IO_OUT, O_IO_OE, O_IO_STATE, O_OUT_LINE, eo, ev;
  logic [4:0] I_STROBE_RATE;
  logic [7:0] I_IO_MODE, I_TX_DATA, O_RX_DATA;
  logic [15:0] I_PIX_DATA, I_PIX_MASK, I_WINDOW_X, I_WINDOW_Y, I_WINDOW_W, I_WINDOW_H;
  logic [15:0] I_LUT_ADDR, I_LUT_DATA, I_LINE_PERIOD, lut [256];
  logic [26:0] I_EXPO_WIDTH;
  logic [31:0] O_FIFO_DATA, w, seed = 32'he6139403, q [$];
  int n_mismatch = 0, cmp_count = 0, t;
  assign I_SER_RX = O_SER_TX;
  always #20 I_CLK_SYS = ~I_CLK_SYS;
  always #16 I_CLK_PIX = ~I_CLK_PIX;
  cfa_top #(.EXPO_MS_CYCLES(50)) dut (.*);
  cfa_cam cam (.i_clk(I_CLK_PIX), .i_go(go), .o_data(I_PIX_DATA), .o_lv(I_LINE_VALID),
    .o_fv(I_FRAME_VALID));
  // ==========
  // helpers
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp4(input logic [3:0] g, input logic [3:0] e);
    cmp32({28'h0, g}, {28'h0, e});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========
  // fifo monitor; an unexpected word meets an unknown note
  always @(posedge I_CLK_SYS) if (!I_RST && O_FIFO_VALID === 1'b1) begin
    cmp32(O_FIFO_DATA, q.size() ? q.pop_front() : 32'hx);
  end
  // ==========
  // main sequence
  initial begin
    {I_EDGE_FALL, I_LV_LOW, I_FV_LOW, I_LINE_SCAN, I_PIX16, I_ACQ_START, I_ACQ_CLEAR,
      I_LUT_WE, I_STROBE_DRIVE, I_STROBE_INVERT, I_CLK_ON_IO, I_LINE_START_EN, I_EXPO_EN,
      I_EXPO_FIRE, I_EXPO_MS, I_SER_BITS8, I_SER_STOP2, I_TX_VALID, I_SUBSAMPLE,
      I_TRIGGER_INPUT, I_SER_PARITY, I_SER_BAUD, I_IO_IN, I_OUT_LEVEL, I_STROBE_RATE,
      I_IO_MODE, I_TX_DATA, I_LUT_ADDR, I_LUT_DATA, I_LINE_PERIOD, I_EXPO_WIDTH} = '0;
    {I_FIFO_READ, I_IRQ_EN, I_PIX_MASK} = {2'b11, 16'h00ff};
    {I_WINDOW_X, I_WINDOW_Y, I_WINDOW_W, I_WINDOW_H} = {16'h1, 16'h1, 16'h4, 16'h2};
    repeat (16) @(posedge I_CLK_SYS);
    @(negedge I_CLK_SYS) I_RST <= 1'b0;
    for (int a = 0; a < 256; a++) begin
      seed = nx(seed);
      lut[a] = seed[15:0];
      {I_LUT_WE, I_LUT_ADDR, I_LUT_DATA} <= {1'b1, 16'(a), seed[15:0]};
      @(negedge I_CLK_SYS);
    end
    I_LUT_WE <= 1'b0;
    for (int y = 1; y < 3; y++) begin
      for (int x = 4; x > 0; x--) w = {w[23:0], lut[y * 16 + x][7:0]};
      q.push_back(w);
    end
    I_ACQ_START <= 1'b1;
    @(negedge I_CLK_SYS) I_ACQ_START <= 1'b0;
    repeat (10) @(negedge I_CLK_SYS);
    go <= 1'b1;
    for (t = 0; t < 3000 && O_ACQ_DONE !== 1'b1; t++) @(negedge I_CLK_SYS);
    if (t == 3000) begin
      n_mismatch++;
      tally_and_finish;
    end
    repeat (10) @(negedge I_CLK_SYS);
    cmp4({3'h0, O_ACQ_IRQ}, 4'h1);
    cmp4(4'(q.size()), 4'h0);
    cmp4({3'h0, O_FIFO_OVERFLOW}, 4'h0);
    I_ACQ_CLEAR <= 1'b1;
    @(negedge I_CLK_SYS) I_ACQ_CLEAR <= 1'b0;
    repeat (2) @(negedge I_CLK_SYS);
    cmp4({3'h0, O_ACQ_DONE}, 4'h0);
    $display("test frame done");
    for (int k = 0; k < 6; k++) begin
      seed = nx(seed);
      {I_IO_MODE, I_IO_IN, I_OUT_LEVEL, I_TRIGGER_INPUT} <= seed[17:0];
      repeat (4) @(negedge I_CLK_SYS);
      for (int i = 0; i < 4; i++) begin
        eo[i] = I_IO_MODE[2*i+:2] == 2'h1 || I_IO_MODE[2*i+:2] == 2'h2;
        ev[i] = I_IO_MODE[2*i+:2] == 2'h1;
      end
      cmp4(O_IO_OE, eo);
      cmp4(O_IO_OUT & eo, ev);
      cmp4({2'h0, O_TRIGGER_STATE}, {2'h0, I_TRIGGER_INPUT});
      cmp4(O_OUT_LINE, I_OUT_LEVEL);
      cmp4(O_IO_STATE, I_IO_IN);
    end
    $display("test lines done");
    {I_SER_BITS8, I_SER_PARITY, I_SER_BAUD} <= {1'b1, 3'h2, 3'h7};
    seed = nx(seed);
    {I_TX_VALID, I_TX_DATA} <= {1'b1, seed[7:0]};
    @(negedge I_CLK_SYS) I_TX_VALID <= 1'b0;
    for (t = 0; t < 6000 && O_RX_VALID !== 1'b1; t++) @(negedge I_CLK_SYS);
    if (t == 6000) begin
      n_mismatch++;
      tally_and_finish;
    end
    cmp32({23'h0, O_RX_ERR, O_RX_DATA}, {24'h0, seed[7:0]});
    $display("test serial done");
    tally_and_finish;
  end
endmodule
